//--- rtl/timer16_capture_ppg_oneshot.sv
// 16-bit timer with two capture/compare registers, pulse generation, one-shot and axi4-lite slave
`timescale 1ns/1ps
`include "timer16_cfg.svh"
// Contract
// - dual capture free-run leaves output unchanged
// - toggle select set inverts output on A edge
// - A edge captures into B, B edge into A
// - only B edges never load register B
// - compare match raises its interrupt, no clear
// - register A capture trigger selects A or B
// - register B captures only on A edges
// - count register read returns current count
// - mode 11 clears on A match, pulses output
// - period A+1, duty (B+1)/(A+1)
// - one-shot needs mode 01/10 and enable bit
// - one-shot trigger clears counter, emits one pulse
// - one-shot matches raise interrupts and invert output
// - mode 00 stops and initialises counter
// - width measurement in free-run and trigger-clear
// - free-run wrap sets overflow, keeps counting
// - mode 01 free-run, 10 clear on A edge
module timer16_capture_ppg_oneshot
  import timer16_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic [7:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [7:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input logic trigger_input_a,
  input logic trigger_input_b,
  output logic timer_output_pin,
  output logic match_interrupt_a,
  output logic match_interrupt_b
);

  function automatic logic valid_edge(input logic prev, input logic cur, input logic [1:0] sel);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    if (sel == `EDGE_FALL) begin
      valid_edge = fall;
    end else if (sel == `EDGE_RISE) begin
      valid_edge = rise;
    end else begin
      valid_edge = rise | fall;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din, input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = din[i*8 +: 8];
      end
    end
  endfunction

  logic [1:0] sync_a_q;
  logic [1:0] sync_b_q;
  logic hist_a_q;
  logic hist_b_q;
  mode_ctrl_s mode_q;
  capture_ctrl_s cap_ctrl_q;
  output_ctrl_s out_ctrl_q;
  prescaler_s pre_q;
  logic [15:0] cnt_q;
  logic [15:0] cca_q;
  logic [15:0] ccb_q;
  logic [`PREDIV_W-1:0] prediv_q;
  os_state_e os_q;
  logic os_half_q;
  logic pin_q;
  logic irq_a_q;
  logic irq_b_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // bus handshakes and register decode
  wire logic aw_hs = awvalid && awready_q;
  wire logic w_hs = wvalid && wready_q;
  wire logic ar_hs = arvalid && arready_q;
  wire logic do_write = !awready_q && !wready_q && !bvalid_q;
  wire logic wr_mode = do_write && waddr_q == `OFS_MODE;
  wire logic wr_cap = do_write && waddr_q == `OFS_CAPCTL;
  wire logic wr_out = do_write && waddr_q == `OFS_OUTCTL;
  wire logic wr_pre = do_write && waddr_q == `OFS_PRESCALE;
  wire logic wr_cca = do_write && waddr_q == `OFS_CCA;
  wire logic wr_ccb = do_write && waddr_q == `OFS_CCB;
  wire logic wr_hit = wr_mode || wr_cap || wr_out || wr_pre || wr_cca || wr_ccb
    || waddr_q == `OFS_COUNT;
  wire logic [31:0] mode_w = merge({28'h0, mode_q}, wdata_q, wstrb_q);
  wire logic [31:0] cap_w = merge({29'h0, cap_ctrl_q}, wdata_q, wstrb_q);
  wire logic [31:0] out_w = merge({29'h0, out_ctrl_q}, wdata_q, wstrb_q);
  wire logic [31:0] pre_w = merge({26'h0, pre_q}, wdata_q, wstrb_q);
  wire logic [31:0] cca_w = merge({16'h0, cca_q}, wdata_q, wstrb_q);
  wire logic [31:0] ccb_w = merge({16'h0, ccb_q}, wdata_q, wstrb_q);
  // trigger bit reads back as zero, so rewriting the control word is harmless
  wire logic ospt_wr = wr_out && out_w[`OUT_OST_BIT];
  wire logic rd_hit = araddr == `OFS_MODE || araddr == `OFS_CAPCTL || araddr == `OFS_OUTCTL
    || araddr == `OFS_PRESCALE || araddr == `OFS_COUNT || araddr == `OFS_CCA || araddr == `OFS_CCB;
  wire logic [31:0] rd_word =
    (araddr == `OFS_MODE) ? {28'h0, mode_q} :
    (araddr == `OFS_CAPCTL) ? {29'h0, cap_ctrl_q} :
    (araddr == `OFS_OUTCTL) ? {29'h0, out_ctrl_q} :
    (araddr == `OFS_PRESCALE) ? {26'h0, pre_q} :
    (araddr == `OFS_COUNT) ? {16'h0, cnt_q} :
    (araddr == `OFS_CCA) ? {16'h0, cca_q} :
    (araddr == `OFS_CCB) ? {16'h0, ccb_q} : 32'h0;

  // timer decode
  wire op_mode_e op = mode_q.op_mode;
  wire logic running = op != OP_STOP;
  wire logic [`PREDIV_W-1:0] div_mask = `PREDIV_W'((`PREDIV_W'(1) << pre_q.div_sel) - `PREDIV_W'(1));
  wire logic tick = running && (&(prediv_q | ~div_mask));
  wire logic edge_a = running && valid_edge(hist_a_q, sync_a_q[1], pre_q.edge_a);
  wire logic edge_b = running && valid_edge(hist_b_q, sync_b_q[1], pre_q.edge_b);
  wire logic dual_cap = cap_ctrl_q.a_capture && cap_ctrl_q.b_capture;
  wire logic match_a = tick && !cap_ctrl_q.a_capture && cnt_q == cca_q;
  wire logic match_b = tick && !cap_ctrl_q.b_capture && cnt_q == ccb_q;
  wire logic os_mode = out_ctrl_q.one_shot_enable && (op == OP_FREE || op == OP_TRIG_CLEAR);
  wire logic os_fire = os_mode && (ospt_wr || edge_a);
  wire logic trig_clear = op == OP_TRIG_CLEAR && edge_a;
  wire logic ppg_clear = op == OP_PPG && tick && cnt_q == cca_q;
  wire logic any_clear = os_fire || trig_clear || ppg_clear;
  wire logic ovf_set = tick && cnt_q == `COUNT_MAX && !any_clear;
  wire logic [15:0] cnt_d = !running ? `RST_CC : any_clear ? `RST_CC : tick ? cnt_q + 16'h0001 : cnt_q;
  // captures run in every counting mode, so both measurement styles work
  wire logic cap_a_hit = cap_ctrl_q.a_capture && (cap_ctrl_q.a_trig_sel_a ? edge_a : edge_b);
  wire logic cap_b_hit = cap_ctrl_q.b_capture && edge_a;
  wire logic os_toggle = match_a || match_b;
  wire logic cmp_toggle = (match_a && out_ctrl_q.invert_on_a) || (match_b && out_ctrl_q.invert_on_b);
  wire logic cap_toggle = dual_cap && mode_q.capture_toggle_select && edge_a;
  wire logic pin_toggle = (os_q == OS_RUN) ? os_toggle : (!os_mode && cmp_toggle) || cap_toggle;
  // output low past register B up to register A, so high time is B+1 counts
  wire logic pin_d = (op == OP_PPG) ? (cnt_d <= ccb_q) : pin_q ^ pin_toggle;

  // trigger pins: two flops, then history flop for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a_q <= 2'b00;
      sync_b_q <= 2'b00;
      hist_a_q <= 1'b0;
      hist_b_q <= 1'b0;
    end else begin
      sync_a_q <= {sync_a_q[0], trigger_input_a};
      sync_b_q <= {sync_b_q[0], trigger_input_b};
      hist_a_q <= sync_a_q[1];
      hist_b_q <= sync_b_q[1];
    end
  end

  // control registers; overflow set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= '{op_mode: OP_STOP, capture_toggle_select: 1'b0, overflow_flag: 1'b0};
      cap_ctrl_q <= '0;
      out_ctrl_q <= '0;
      pre_q <= '0;
    end else begin
      if (wr_mode) begin
        mode_q.op_mode <= op_mode_e'(mode_w[`MODE_OP_HI:`MODE_OP_LO]);
        mode_q.capture_toggle_select <= mode_w[`MODE_CTS_BIT];
      end
      mode_q.overflow_flag <= ovf_set || (wr_mode ? mode_w[`MODE_OVF_BIT] : mode_q.overflow_flag);
      if (wr_cap) begin
        cap_ctrl_q <= '{b_capture: cap_w[`CAP_B_CAPTURE_BIT], a_trig_sel_a: cap_w[`CAP_A_SEL_BIT],
          a_capture: cap_w[`CAP_A_CAPTURE_BIT]};
      end
      if (wr_out) begin
        out_ctrl_q <= '{one_shot_enable: out_w[`OUT_OSE_BIT], invert_on_b: out_w[`OUT_INV_B_BIT],
          invert_on_a: out_w[`OUT_INV_A_BIT]};
      end
      if (wr_pre) begin
        pre_q <= '{edge_b: pre_w[`PRE_EDGE_B_HI:`PRE_EDGE_B_LO], edge_a: pre_w[`PRE_EDGE_A_HI:`PRE_EDGE_A_LO],
          div_sel: pre_w[`PRE_DIV_HI:`PRE_DIV_LO]};
      end
    end
  end

  // counter, prescaler and capture/compare registers; a capture beats a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= `RST_CC;
      cca_q <= `RST_CC;
      ccb_q <= `RST_CC;
      prediv_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      prediv_q <= running ? prediv_q + `PREDIV_W'(1) : '0;
      cca_q <= cap_a_hit ? cnt_q : wr_cca ? cca_w[15:0] : cca_q;
      ccb_q <= cap_b_hit ? cnt_q : wr_ccb ? ccb_w[15:0] : ccb_q;
    end
  end

  // one-shot sequencer: two inversions make the single pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      os_q <= OS_IDLE;
      os_half_q <= 1'b0;
    end else if (!os_mode) begin
      os_q <= OS_IDLE;
      os_half_q <= 1'b0;
    end else if (os_fire) begin
      os_q <= OS_RUN;
      os_half_q <= 1'b0;
    end else if (os_q == OS_RUN && os_toggle) begin
      os_q <= os_half_q ? OS_IDLE : OS_RUN;
      os_half_q <= ~os_half_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      irq_a_q <= match_a || cap_a_hit;
      irq_b_q <= match_b || cap_b_hit;
    end
  end

  // axi4-lite write path: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        awready_q <= 1'b0;
        waddr_q <= awaddr;
      end
      if (w_hs) begin
        wready_q <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign timer_output_pin = pin_q;
  assign match_interrupt_a = irq_a_q;
  assign match_interrupt_b = irq_b_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_stop_init: assert property (op == OP_STOP |=> cnt_q == `RST_CC)
    else $error("counter not zero while stopped");
  a_wrap_overflow: assert property (ovf_set |=> cnt_q == 16'h0000 && mode_q.overflow_flag)
    else $error("wrap did not clear count and set overflow");
  a_ppg_restart: assert property (ppg_clear |=> cnt_q == 16'h0000)
    else $error("pulse mode did not restart on register A match");
  a_ppg_duty: assert property (op == OP_PPG && !wr_ccb && !cap_b_hit |=> pin_q == (cnt_q <= ccb_q))
    else $error("pulse output level wrong for count");
  a_capture_b_edge: assert property (cap_b_hit |=> ccb_q == $past(cnt_q) && match_interrupt_b)
    else $error("register B did not capture count");
  a_capture_a_sel: assert property (cap_a_hit |=> cca_q == $past(cnt_q) && match_interrupt_a)
    else $error("register A did not capture count");
  a_dual_no_toggle: assert property (dual_cap && !mode_q.capture_toggle_select && op == OP_FREE
    && os_q == OS_IDLE |=> $stable(pin_q))
    else $error("output moved in dual capture mode");
  a_cap_toggle_out: assert property (op == OP_FREE && os_q == OS_IDLE && !os_mode && !cmp_toggle
    && cap_toggle |=> pin_q != $past(pin_q))
    else $error("output not inverted on trigger A edge");
  // a match at the top of the count wraps legally, so check the step, not a nonzero count
  a_match_irq: assert property (match_a |=> match_interrupt_a && (cnt_q == 16'($past(cnt_q) + 16'h0001)
    || $past(any_clear) || op != OP_FREE))
    else $error("match did not raise interrupt or cleared count");
  a_oneshot_start: assert property (os_fire |=> os_q == OS_RUN && cnt_q == 16'h0000)
    else $error("one-shot trigger did not restart counter");
  a_oneshot_invert: assert property (os_q == OS_RUN && os_mode && !os_fire && match_b
    |=> pin_q != $past(pin_q) && match_interrupt_b)
    else $error("one-shot match did not invert output");
  a_count_hold: assert property (running && !tick && !any_clear |=> $stable(cnt_q))
    else $error("counter moved without count enable");
  a_count_read: assert property (ar_hs && araddr == `OFS_COUNT |=> rvalid_q && rdata_q == {16'h0, $past(cnt_q)})
    else $error("count read returned wrong value");

  c_ppg_period: cover property (ppg_clear ##1 op == OP_PPG [*3] ##1 ppg_clear);
  c_oneshot_done: cover property (os_q == OS_RUN ##1 os_q == OS_IDLE);
  c_overflow: cover property (ovf_set);
  c_dual_capture: cover property (dual_cap && cap_b_hit);
endmodule

//--- rtl/timer16_cfg.svh
// offsets, field positions, reset values and encodings of the timer block
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH
`define OFS_MODE 8'h00
`define OFS_CAPCTL 8'h04
`define OFS_OUTCTL 8'h08
`define OFS_PRESCALE 8'h0c
`define OFS_COUNT 8'h10
`define OFS_CCA 8'h14
`define OFS_CCB 8'h18
`define MODE_OVF_BIT 0
`define MODE_CTS_BIT 1
`define MODE_OP_LO 2
`define MODE_OP_HI 3
`define CAP_A_CAPTURE_BIT 0
`define CAP_A_SEL_BIT 1
`define CAP_B_CAPTURE_BIT 2
`define OUT_INV_A_BIT 0
`define OUT_INV_B_BIT 1
`define OUT_OSE_BIT 2
`define OUT_OST_BIT 3
`define PRE_DIV_LO 0
`define PRE_DIV_HI 1
`define PRE_EDGE_A_LO 2
`define PRE_EDGE_A_HI 3
`define PRE_EDGE_B_LO 4
`define PRE_EDGE_B_HI 5
`define EDGE_FALL 2'b00
`define EDGE_RISE 2'b01
`define RST_CC 16'h0000
`define COUNT_MAX 16'hffff
`define PREDIV_W 3
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11
`endif

//--- rtl/timer16_pkg.sv
// types shared by the timer block
package timer16_pkg;
  typedef enum logic [1:0] {
    OP_STOP = 2'b00,
    OP_FREE = 2'b01,
    OP_TRIG_CLEAR = 2'b10,
    OP_PPG = 2'b11
  } op_mode_e;
  typedef enum logic [1:0] {
    OS_IDLE = 2'b01,
    OS_RUN = 2'b10
  } os_state_e;
  typedef struct packed {
    op_mode_e op_mode;
    logic capture_toggle_select;
    logic overflow_flag;
  } mode_ctrl_s;
  typedef struct packed {
    logic b_capture;
    logic a_trig_sel_a;
    logic a_capture;
  } capture_ctrl_s;
  typedef struct packed {
    logic one_shot_enable;
    logic invert_on_b;
    logic invert_on_a;
  } output_ctrl_s;
  typedef struct packed {
    logic [1:0] edge_b;
    logic [1:0] edge_a;
    logic [1:0] div_sel;
  } prescaler_s;
endpackage

//--- tb/pulse_source.sv
// external pulse source driving the two trigger pins
`timescale 1ns/1ps
module pulse_source (
  input wire logic aclk,
  input wire logic fire_a,
  input wire logic fire_b,
  output logic trig_a,
  output logic trig_b
);
  // toggling only: the timer is set to take both edges as valid
  initial begin
    trig_a = 1'b0;
    trig_b = 1'b0;
  end
  always @(posedge aclk) begin
    if (fire_a) trig_a <= ~trig_a;
    if (fire_b) trig_b <= ~trig_b;
  end
endmodule

//--- tb/testbench.sv
// self-checking bench for the 16-bit capture/compare timer
`timescale 1ns/1ps
`include "timer16_cfg.svh"
module testbench;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, u, t;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic trig_a, trig_b, fire_a, fire_b, pin, irq_a, irq_b, p;
  int fail_count, checked, h, e, ia, ib;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] br; logic [1:0] rr;} row_s;
  row_s rows [7] = '{
    '{`OFS_CCA, 32'hffff1234, 32'h00001234, `RESP_OKAY, `RESP_OKAY},
    '{`OFS_CCB, 32'h0000abcd, 32'h0000abcd, `RESP_OKAY, `RESP_OKAY},
    '{`OFS_COUNT, 32'h00000055, 32'h00000000, `RESP_OKAY, `RESP_OKAY},
    '{`OFS_CAPCTL, 32'h00000007, 32'h00000007, `RESP_OKAY, `RESP_OKAY},
    '{`OFS_OUTCTL, 32'h0000000b, 32'h00000003, `RESP_OKAY, `RESP_OKAY},
    '{`OFS_PRESCALE, 32'h0000003f, 32'h0000003f, `RESP_OKAY, `RESP_OKAY},
    '{8'h40, 32'h00000005, 32'h00000000, `RESP_DECERR, `RESP_DECERR}};

  timer16_capture_ppg_oneshot u_timer16_capture_ppg_oneshot (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .trigger_input_a(trig_a), .trigger_input_b(trig_b), .timer_output_pin(pin),
    .match_interrupt_a(irq_a), .match_interrupt_b(irq_b));
  pulse_source u_pulse_source (.aclk(aclk), .fire_a(fire_a), .fire_b(fire_b), .trig_a(trig_a), .trig_b(trig_b));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, x, s);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] res);
    logic aw;
    logic w;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    {awvalid, wvalid, bready} <= 3'h7;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wready === 1'b1) begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    res = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] res);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    res = rresp;
    rready <= 1'b0;
  endtask

  // one toggle request on trigger a (b=0) or trigger b (b=1)
  task automatic fire(input logic b);
    if (b) fire_b <= 1'b1;
    else fire_a <= 1'b1;
    @(posedge aclk);
    if (b) fire_b <= 1'b0;
    else fire_a <= 1'b0;
  endtask

  task summarize;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #2500000;
    fail_count++;
    summarize();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, fire_a, fire_b, aresetn} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      axr(8'(i * 4), v, r);
      chk("reset value", v, 32'h0);
    end
    chk("reset pin", pin, 1'b0);
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].d, r);
      chk("bresp", r, rows[i].br);
      axr(rows[i].a, v, r);
      chk("rdata", v, rows[i].q);
      chk("rresp", r, rows[i].rr);
    end
    axw(`OFS_OUTCTL, 32'h0, r);
    // span between edges 40 cycles; divide by 2 halves the captured span
    for (int k = 0; k < 2; k++) begin
      axw(`OFS_MODE, 32'h0, r);
      axw(`OFS_PRESCALE, 32'h3c | k, r);
      axw(`OFS_CAPCTL, 32'h5, r);
      axw(`OFS_MODE, 32'h4, r);
      p = pin;
      fire(0);
      waitc(39);
      fire(1);
      waitc(8);
      axr(`OFS_CCA, v, r);
      axr(`OFS_CCB, u, r);
      chk("capture span", 16'(v - u), 32'd40 >> k);
      chk("pin held", pin, p);
      fire(1);
      waitc(8);
      axr(`OFS_CCB, t, r);
      chk("b kept", t, u);
      axr(`OFS_CCA, t, r);
      chk("a moved", t != v, 1'b1);
    end
    axw(`OFS_CAPCTL, 32'h7, r);
    fire(0);
    waitc(8);
    axr(`OFS_CCA, v, r);
    axr(`OFS_CCB, u, r);
    chk("a on a edge", v, u);
    axw(`OFS_MODE, 32'h6, r);
    p = pin;
    for (int k = 0; k < 2; k++) begin
      fire(0);
      waitc(8);
      chk("toggle", pin, p ^ !k);
    end
    axw(`OFS_MODE, 32'h0, r);
    waitc(20);
    axr(`OFS_COUNT, v, r);
    chk("stopped count", v, 32'h0);
    axw(`OFS_PRESCALE, 32'h3c, r);
    axw(`OFS_CAPCTL, 32'h0, r);
    axw(`OFS_CCA, 32'd50, r);
    axw(`OFS_MODE, 32'h4, r);
    ia = 0;
    repeat (300) begin
      @(posedge aclk);
      ia += irq_a;
    end
    chk("match irq", ia, 1);
    axr(`OFS_COUNT, v, r);
    chk("no clear", v > 32'd290, 1'b1);
    axw(`OFS_MODE, 32'h0, r);
    axw(`OFS_CCA, 32'd9, r);
    axw(`OFS_CCB, 32'd3, r);
    axw(`OFS_MODE, 32'hc, r);
    waitc(30);
    p = pin;
    h = 0;
    e = 0;
    repeat (100) begin
      @(posedge aclk);
      h += pin;
      e += (pin && !p);
      p = pin;
    end
    chk("ppg high", h, 40);
    chk("ppg rises", e, 10);
    // one trigger gives one pulse from the B match to the A match, 15 cycles, and one interrupt from each match
    for (int k = 0; k < 2; k++) begin
      axw(`OFS_MODE, 32'h0, r);
      axw(`OFS_CCA, 32'd20, r);
      axw(`OFS_CCB, 32'd5, r);
      axw(`OFS_OUTCTL, 32'h4, r);
      axw(`OFS_MODE, k ? 32'h8 : 32'h4, r);
      waitc(30);
      p = pin;
      if (k) fire(0);
      else axw(`OFS_OUTCTL, 32'hc, r);
      h = 0;
      ia = 0;
      ib = 0;
      repeat (200) begin
        @(posedge aclk);
        h += (pin !== p);
        ia += irq_a;
        ib += irq_b;
      end
      chk("pulse width", h, 15);
      chk("one-shot irq a", ia, 1);
      chk("one-shot irq b", ib, 1);
    end
    axw(`OFS_MODE, 32'h0, r);
    axw(`OFS_MODE, 32'h4, r);
    waitc(65600);
    axr(`OFS_MODE, v, r);
    chk("overflow set", v[`MODE_OVF_BIT], 1'b1);
    axr(`OFS_COUNT, v, r);
    chk("wrapped", v < 32'd300, 1'b1);
    axw(`OFS_MODE, 32'h4, r);
    axr(`OFS_MODE, v, r);
    chk("overflow clear", v[`MODE_OVF_BIT], 1'b0);
    summarize();
  end
endmodule
